// file: fcp_link_rx.sv
// Shared constants of the flow sensor command port and the SCL-side shifter
// Summary of operation
// - Alarm line low when a reading waits
// - Readings every 0.5 ms times averaging count
// - Taking a reading releases the alarm high
// - Read header without fresh data gets NACK
// - Alarm low after reset until measurement start
// - Start command releases alarm until first reading
// - After reset reads are NACKed; host infers reset
// - Failed memory check disables the serial port
// - Product identifier command selects identifier readout
// - Address 0x2A plus strap selection up to 0x2D
// - 16-bit command, optional argument plus checksum
// - Read words each followed by checksum byte
// - Host NACK ends a read; stop driving
// - Start code picks gas table; two reserved
// - Mixture starts carry per mille argument
// - Measure continuously; each read returns newest results
// - First reading 12 ms after start accepted
// - Bytes four to six carry temperature and checksum
// - Flow and temperature raw signed, MSB first
// - Status holds command index, averaging, concentration
// - Stop command idles; ready within 0.5 ms
// - While measuring only stop, concentration update or pointer reset
// - Concentration above 1000 stops the measurement
`timescale 1ns/1ns
`default_nettype none

package fcp_pkg;
  localparam int CLK_MHZ = 125;
  localparam int T_FIRST_US = 12000;
  localparam int T_TICK_US = 500;
  localparam int T_STOP_US = 500;
  localparam int FIRST_CYC = T_FIRST_US * CLK_MHZ;
  localparam int TICK_CYC = T_TICK_US * CLK_MHZ;
  localparam int STOP_CYC = T_STOP_US * CLK_MHZ;
  localparam int AVG_N = 1;
  localparam int TMR_W = 21;
  localparam logic [6:0] ADDR_BASE = 7'h2a;
  localparam logic [15:0] CMD_STOP = 16'h3ff9;
  localparam logic [15:0] CMD_CONC = 16'he17d;
  localparam logic [15:0] CMD_PTR_RST = 16'he000;
  localparam logic [15:0] CMD_PROD_ID = 16'he102;
  localparam int N_START = 9;
  localparam logic [N_START-1:0][15:0] START_CODES = {
    16'h3646, 16'h3639, 16'h3632, 16'h362f, 16'h3624,
    16'h361e, 16'h3615, 16'h3608, 16'h3603};
  localparam logic [3:0] IDX_RSV_LO = 4'h4;
  localparam logic [3:0] IDX_MIX_LO = 4'h6;
  localparam logic [9:0] CONC_PURE = 10'h3ff;
  localparam logic [15:0] CONC_MAX = 16'h03e8;
  localparam logic AVG_MODE = 1'b0;
  localparam logic SMOOTH_ON = 1'b0;
  localparam logic [2:0] LEN_CMD = 3'h2;
  localparam logic [2:0] LEN_ARG = 3'h5;
  localparam logic [2:0] LEN_SAT = 3'h7;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BITS_BYTE = 4'h8;
  localparam logic [1:0] POS_MSB = 2'h0;
  localparam logic [1:0] POS_LSB = 2'h1;
  localparam logic [1:0] POS_CRC = 2'h2;
  localparam logic [1:0] WORD_LAST = 2'h3;
  localparam logic [15:0] WORD_FILL = 16'hffff;
  localparam logic [7:0] CRC_POLY = 8'h31;
  localparam logic [7:0] CRC_INIT = 8'hff;

  // Checksum over one 16-bit word, MSB first
  function automatic logic [7:0] crc8(input logic [15:0] w);
    logic [7:0] c;
    c = CRC_INIT;
    for (int i = 15; i >= 0; i--) begin
      if (c[7] ^ w[i]) begin
        c = {c[6:0], 1'b0} ^ CRC_POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    return c;
  endfunction : crc8
endpackage : fcp_pkg

// Shifts SDA in on each SCL rise; read by the system side after the rise
module fcp_link_rx (
  input wire logic scl_i,
  input wire logic sda_i,
  output logic [7:0] rx_byte_o
);
  typedef struct packed {
    logic [7:0] sh;
  } fcp_lrx_t;

  fcp_lrx_t st_ff;
  fcp_lrx_t nxt_st;

  // Next shift value
  always_comb begin
    nxt_st = st_ff;
    nxt_st.sh = {st_ff.sh[6:0], sda_i};
  end

  // Link clock register, no reset as the clock stands outside frames
  always_ff @(posedge scl_i) begin
    st_ff <= nxt_st;
  end

  assign rx_byte_o = st_ff.sh;
endmodule : fcp_link_rx
`default_nettype wire

// file: fcp_cmd_port.sv
// Flow sensor serial command port: target engine, commands, measurement
`timescale 1ns/1ns
`default_nettype none

module fcp_cmd_port #(
  parameter int FIRST_CYC = fcp_pkg::FIRST_CYC,
  parameter int TICK_CYC = fcp_pkg::TICK_CYC,
  parameter int STOP_CYC = fcp_pkg::STOP_CYC,
  // Arbitrary identifier value
  parameter logic [31:0] PRODUCT_ID = 32'h0000_0101
) (
  input wire logic CLK_SYS_I,
  input wire logic SYS_RST_I,
  input wire logic SCL_I,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE_O,
  input wire logic [1:0] ADDR_SEL_I,
  input wire logic MEM_CHECK_DONE_I,
  input wire logic MEM_CHECK_OK_I,
  input wire logic [15:0] FLOW_I,
  input wire logic [15:0] TEMP_I,
  output logic DATA_READY_ALARM_N_O
);
  localparam int TW = fcp_pkg::TMR_W;
  localparam logic [TW-1:0] FIRST_LD = TW'(FIRST_CYC - 1);
  localparam logic [TW-1:0] TICK_LD = TW'(TICK_CYC * fcp_pkg::AVG_N - 1);
  localparam logic [TW-1:0] STOP_LD = TW'(STOP_CYC - 1);

  typedef enum logic [6:0] {
    S_IDLE = 7'h01,
    S_ADDR = 7'h02,
    S_AACK = 7'h04,
    S_WR = 7'h08,
    S_WACK = 7'h10,
    S_RD = 7'h20,
    S_RACK = 7'h40
  } fcp_bus_t;

  typedef struct packed {
    fcp_bus_t bus;
    logic [2:0] scl_sy;
    logic [2:0] sda_sy;
    logic scl_lv;
    logic sda_lv;
    logic [3:0] bit_cnt;
    logic ack_drv;
    logic ack_ok;
    logic rw;
    logic sda_oe;
    logic [7:0] tx;
    logic [1:0] rd_word;
    logic [1:0] rd_pos;
    logic [3:0][15:0] wd;
    logic [2:0] wr_cnt;
    logic [15:0] cmd;
    logic [15:0] arg;
    logic [7:0] arg_crc;
    logic strap_done;
    logic [1:0] addr_sel;
    logic chk_done;
    logic if_ok;
    logic meas;
    logic stop_wait;
    logic [3:0] idx;
    logic [9:0] conc;
    logic ptr_id;
    logic has_data;
    logic dr_n;
    logic [TW-1:0] tmr;
    logic [15:0] flow;
    logic [15:0] temp;
    logic sv_seen;
    logic sv_first;
    logic [TW-1:0] sv_since;
  } fcp_state_t;

  // Pin filters start at the idle-high bus level so no false edge follows
  localparam fcp_state_t RST_ST = '{bus: S_IDLE, scl_sy: '1, sda_sy: '1,
    scl_lv: 1'b1, sda_lv: 1'b1, default: '0};

  fcp_state_t st_ff;
  fcp_state_t nxt_st;
  logic [7:0] rx_byte;
  logic scl_rise;
  logic scl_fall;
  logic tick;
  logic start_acc;
  logic addr_eval;
  logic addr_ack;
  logic exec;
  logic crc_ok;
  logic stop_cmd;

  // SCL-domain receive shifter
  fcp_link_rx u_link_rx (
    .scl_i(SCL_I),
    .sda_i(SDA_I),
    .rx_byte_o(rx_byte)
  );

  // Whole next-state computation
  always_comb begin
    logic scl_new;
    logic sda_new;
    logic bus_start;
    logic bus_stop;
    logic do_load;
    logic khit;
    logic len_cmd;
    logic len_arg;
    logic [3:0] kidx;
    logic [15:0] cur;
    logic [7:0] ld_byte;
    scl_new = st_ff.scl_lv;
    sda_new = st_ff.sda_lv;
    bus_start = 1'b0;
    bus_stop = 1'b0;
    do_load = 1'b0;
    khit = 1'b0;
    len_cmd = 1'b0;
    len_arg = 1'b0;
    kidx = '0;
    cur = st_ff.wd[st_ff.rd_word];
    ld_byte = '0;
    nxt_st = st_ff;
    tick = 1'b0;
    start_acc = 1'b0;
    addr_eval = 1'b0;
    addr_ack = 1'b0;
    exec = 1'b0;
    stop_cmd = 1'b0;
    crc_ok = (fcp_pkg::crc8(st_ff.arg) == st_ff.arg_crc);

    // Pin synchronisers; a level counts once stages two and three agree
    nxt_st.scl_sy = {st_ff.scl_sy[1:0], SCL_I};
    nxt_st.sda_sy = {st_ff.sda_sy[1:0], SDA_I};
    if (st_ff.scl_sy[1] == st_ff.scl_sy[2]) begin
      scl_new = st_ff.scl_sy[2];
    end
    if (st_ff.sda_sy[1] == st_ff.sda_sy[2]) begin
      sda_new = st_ff.sda_sy[2];
    end
    nxt_st.scl_lv = scl_new;
    nxt_st.sda_lv = sda_new;
    scl_rise = scl_new && !st_ff.scl_lv;
    scl_fall = !scl_new && st_ff.scl_lv;
    bus_start = !sda_new && st_ff.sda_lv && scl_new && st_ff.scl_lv;
    bus_stop = sda_new && !st_ff.sda_lv && scl_new && st_ff.scl_lv;

    // Strap and memory check are taken once after reset release
    if (!st_ff.strap_done) begin
      nxt_st.strap_done = 1'b1;
      nxt_st.addr_sel = ADDR_SEL_I;
    end
    if (MEM_CHECK_DONE_I && !st_ff.chk_done) begin
      nxt_st.chk_done = 1'b1;
      nxt_st.if_ok = MEM_CHECK_OK_I;
    end

    // Next read byte: MSB, LSB, then checksum of the word
    unique case (st_ff.rd_pos)
      fcp_pkg::POS_MSB: ld_byte = cur[15:8];
      fcp_pkg::POS_LSB: ld_byte = cur[7:0];
      default: ld_byte = fcp_pkg::crc8(cur);
    endcase

    // Byte-level target engine
    unique case (st_ff.bus)
      S_IDLE: begin
      end
      S_ADDR, S_WR: begin
        if (scl_rise) begin
          nxt_st.bit_cnt = st_ff.bit_cnt + 4'h1;
          if (st_ff.bit_cnt == fcp_pkg::BIT_LAST) begin
            nxt_st.bit_cnt = '0;
            nxt_st.ack_drv = 1'b0;
            nxt_st.ack_ok = 1'b1;
            if (st_ff.bus == S_ADDR) begin
              addr_eval = 1'b1;
              nxt_st.rw = rx_byte[0];
              nxt_st.bus = S_AACK;
              addr_ack = st_ff.if_ok && !st_ff.stop_wait &&
                (rx_byte[7:1] ==
                 fcp_pkg::ADDR_BASE + 7'(st_ff.addr_sel)) &&
                (!rx_byte[0] || st_ff.ptr_id ||
                 (st_ff.meas && st_ff.has_data));
              nxt_st.ack_ok = addr_ack;
              if (addr_ack && rx_byte[0]) begin
                nxt_st.rd_word = '0;
                nxt_st.rd_pos = fcp_pkg::POS_MSB;
                if (st_ff.ptr_id) begin
                  nxt_st.wd = {fcp_pkg::WORD_FILL, fcp_pkg::WORD_FILL,
                    PRODUCT_ID[15:0], PRODUCT_ID[31:16]};
                end else begin
                  // Newest flow, temperature, status in that order
                  nxt_st.wd = {fcp_pkg::WORD_FILL,
                    st_ff.idx, fcp_pkg::SMOOTH_ON, fcp_pkg::AVG_MODE,
                    st_ff.conc,
                    st_ff.temp, st_ff.flow};
                  nxt_st.has_data = 1'b0;
                  nxt_st.dr_n = 1'b1;
                end
              end
            end else begin
              // Command, argument and checksum bytes in arrival order
              unique case (st_ff.wr_cnt)
                3'h0: nxt_st.cmd[15:8] = rx_byte;
                3'h1: nxt_st.cmd[7:0] = rx_byte;
                3'h2: nxt_st.arg[15:8] = rx_byte;
                3'h3: nxt_st.arg[7:0] = rx_byte;
                3'h4: nxt_st.arg_crc = rx_byte;
                default: begin
                end
              endcase
              if (st_ff.wr_cnt != fcp_pkg::LEN_SAT) begin
                nxt_st.wr_cnt = st_ff.wr_cnt + 3'h1;
              end
              nxt_st.bus = S_WACK;
            end
          end
        end
      end
      S_AACK, S_WACK: begin
        if (scl_fall) begin
          if (!st_ff.ack_drv) begin
            nxt_st.ack_drv = 1'b1;
            nxt_st.sda_oe = st_ff.ack_ok;
          end else begin
            nxt_st.ack_drv = 1'b0;
            nxt_st.sda_oe = 1'b0;
            if (!st_ff.ack_ok) begin
              nxt_st.bus = S_IDLE;
            end else if (st_ff.bus == S_AACK && st_ff.rw) begin
              do_load = 1'b1;
            end else begin
              nxt_st.bus = S_WR;
            end
          end
        end
      end
      S_RD: begin
        if (scl_rise) begin
          nxt_st.bit_cnt = st_ff.bit_cnt + 4'h1;
        end
        if (scl_fall) begin
          if (st_ff.bit_cnt == fcp_pkg::BITS_BYTE) begin
            nxt_st.sda_oe = 1'b0;
            nxt_st.bit_cnt = '0;
            nxt_st.bus = S_RACK;
          end else begin
            nxt_st.tx = {st_ff.tx[6:0], 1'b0};
            nxt_st.sda_oe = !st_ff.tx[6];
          end
        end
      end
      S_RACK: begin
        if (scl_rise) begin
          nxt_st.ack_ok = !sda_new;
        end
        if (scl_fall) begin
          if (st_ff.ack_ok) begin
            do_load = 1'b1;
          end else begin
            nxt_st.bus = S_IDLE;
          end
        end
      end
      default: nxt_st.bus = S_IDLE;
    endcase

    // Load a read byte and drive its first bit
    if (do_load) begin
      nxt_st.tx = ld_byte;
      nxt_st.sda_oe = !ld_byte[7];
      nxt_st.bit_cnt = '0;
      nxt_st.bus = S_RD;
      if (st_ff.rd_pos == fcp_pkg::POS_CRC) begin
        nxt_st.rd_pos = fcp_pkg::POS_MSB;
        if (st_ff.rd_word != fcp_pkg::WORD_LAST) begin
          nxt_st.rd_word = st_ff.rd_word + 2'h1;
        end
      end else begin
        nxt_st.rd_pos = st_ff.rd_pos + 2'h1;
      end
    end

    // START or STOP ends any transfer; a finished write is executed
    if (bus_start || bus_stop) begin
      exec = (st_ff.bus == S_WR) || (st_ff.bus == S_WACK);
      nxt_st.bus = bus_start ? S_ADDR : S_IDLE;
      nxt_st.bit_cnt = '0;
      nxt_st.wr_cnt = '0;
      nxt_st.sda_oe = 1'b0;
      nxt_st.ack_drv = 1'b0;
    end

    // Measurement and stop timers; a new reading wins over a read clear
    if (st_ff.meas) begin
      if (st_ff.tmr == '0) begin
        tick = 1'b1;
        nxt_st.tmr = TICK_LD;
        nxt_st.flow = FLOW_I;
        nxt_st.temp = TEMP_I;
        nxt_st.has_data = 1'b1;
        nxt_st.dr_n = 1'b0;
      end else begin
        nxt_st.tmr = st_ff.tmr - TW'(1);
      end
    end else if (st_ff.stop_wait) begin
      if (st_ff.tmr == '0) begin
        nxt_st.stop_wait = 1'b0;
      end else begin
        nxt_st.tmr = st_ff.tmr - TW'(1);
      end
    end

    // Gas table lookup of the received command
    for (int k = 0; k < fcp_pkg::N_START; k++) begin
      if (st_ff.cmd == fcp_pkg::START_CODES[k]) begin
        khit = 1'b1;
        kidx = 4'(k);
      end
    end
    len_cmd = (st_ff.wr_cnt == fcp_pkg::LEN_CMD);
    len_arg = (st_ff.wr_cnt == fcp_pkg::LEN_ARG) && crc_ok;

    // Command execution at the end of a write transfer
    if (exec) begin
      if (st_ff.meas) begin
        // Other commands are dropped while measuring
        if (len_cmd && st_ff.cmd == fcp_pkg::CMD_STOP) begin
          stop_cmd = 1'b1;
          nxt_st.meas = 1'b0;
          nxt_st.stop_wait = 1'b1;
          nxt_st.tmr = STOP_LD;
          nxt_st.has_data = tick; // A reading in this cycle stands
        end else if (len_arg && st_ff.cmd == fcp_pkg::CMD_CONC) begin
          if (st_ff.arg > fcp_pkg::CONC_MAX) begin
            nxt_st.meas = 1'b0;
            nxt_st.has_data = tick; // A reading in this cycle stands
          end else begin
            nxt_st.conc = st_ff.arg[9:0];
          end
        end else if (len_cmd && st_ff.cmd == fcp_pkg::CMD_PTR_RST) begin
          nxt_st.ptr_id = 1'b0;
        end
      end else if (!st_ff.stop_wait) begin
        if (len_cmd && st_ff.cmd == fcp_pkg::CMD_PTR_RST) begin
          nxt_st.ptr_id = 1'b0;
        end else if (len_cmd && st_ff.cmd == fcp_pkg::CMD_PROD_ID) begin
          nxt_st.ptr_id = 1'b1;
        end else if (khit && len_cmd && kidx < fcp_pkg::IDX_RSV_LO) begin
          start_acc = 1'b1;
          nxt_st.conc = fcp_pkg::CONC_PURE;
        end else if (khit && len_arg && kidx >= fcp_pkg::IDX_MIX_LO &&
                     st_ff.arg <= fcp_pkg::CONC_MAX) begin
          start_acc = 1'b1;
          nxt_st.conc = st_ff.arg[9:0];
        end
      end
    end

    // Accepted start: alarm released until the first reading
    if (start_acc) begin
      nxt_st.meas = 1'b1;
      nxt_st.idx = kidx;
      nxt_st.ptr_id = 1'b0;
      nxt_st.has_data = 1'b0;
      nxt_st.dr_n = 1'b1;
      nxt_st.tmr = FIRST_LD;
      nxt_st.sv_seen = 1'b1;
      nxt_st.sv_first = 1'b1;
    end

    // Cycle count since last start or reading
    if (start_acc || tick) begin
      nxt_st.sv_since = '0;
      if (tick) begin
        nxt_st.sv_first = 1'b0;
      end
    end else if (st_ff.sv_since != '1) begin
      nxt_st.sv_since = st_ff.sv_since + TW'(1);
    end
  end

  // State register; reset leaves the alarm line low
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      st_ff <= RST_ST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign SDA_O = 1'b0;
  assign SDA_OE_O = st_ff.sda_oe;
  assign DATA_READY_ALARM_N_O = st_ff.dr_n;

  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (SYS_RST_I);

  sequence s_hdr_ok;
    addr_eval && rx_byte[0] && addr_ack && !st_ff.ptr_id;
  endsequence

  sequence s_hdr_early;
    addr_eval && rx_byte[0] && !st_ff.ptr_id && !st_ff.has_data;
  endsequence

  sequence s_host_nack;
    st_ff.bus == S_RACK && !st_ff.ack_ok && scl_fall;
  endsequence

  a_idle_alarm_low: assert property (
    !st_ff.sv_seen |-> !DATA_READY_ALARM_N_O)
    else $error("alarm not low before first start");
  a_start_release: assert property (
    start_acc |=> DATA_READY_ALARM_N_O [*3])
    else $error("alarm not released after start");
  a_tick_alarm: assert property (
    tick |=> !DATA_READY_ALARM_N_O && st_ff.has_data)
    else $error("new reading did not pull alarm low");
  a_read_clears: assert property (
    s_hdr_ok ##0 !tick |=> DATA_READY_ALARM_N_O && !st_ff.has_data)
    else $error("read did not release alarm");
  a_nack_early: assert property (
    s_hdr_early |-> !addr_ack ##1 (st_ff.bus == S_AACK && !st_ff.ack_ok))
    else $error("read without data was acknowledged");
  a_first_delay: assert property (
    tick && st_ff.sv_first |-> st_ff.sv_since == FIRST_LD)
    else $error("first reading at wrong time");
  a_tick_period: assert property (
    tick && !st_ff.sv_first |-> st_ff.sv_since == TICK_LD)
    else $error("reading period wrong");
  a_dead_quiet: assert property (
    !st_ff.if_ok |-> !SDA_OE_O)
    else $error("disabled port drove SDA");
  a_nack_release: assert property (
    s_host_nack |=> !SDA_OE_O && st_ff.bus == S_IDLE)
    else $error("data driven after host NACK");
  a_stop_idle: assert property (
    stop_cmd |=> !st_ff.meas && st_ff.stop_wait && st_ff.tmr == STOP_LD)
    else $error("stop command did not idle");
  a_crc_gate: assert property (
    exec && st_ff.wr_cnt == fcp_pkg::LEN_ARG && !crc_ok |-> !start_acc)
    else $error("argument with bad checksum acted on");
endmodule : fcp_cmd_port
`default_nettype wire

// file: fcp_host_model.sv
// Behavioural serial bus host that frames traffic for the command port
`timescale 1ns/1ns
`default_nettype none

module fcp_host_model (
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  // Bus idles released; the clock stands still between frames
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end

  // Start: data falls while the clock is high
  task automatic start();
    #3;
    sda_low_o = 1'b1;
    #40;
    scl_o = 1'b0;
  endtask : start

  // One 80 ns clock period; the wire is sampled mid high phase
  task automatic bit_io(input logic b, output logic s);
    #20;
    sda_low_o = ~b;
    #20;
    scl_o = 1'b1;
    #20;
    s = sda_i;
    #20;
    scl_o = 1'b0;
  endtask : bit_io

  // Byte out MSB first, then the target's acknowledge
  task automatic tx_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], s);
    end
    bit_io(1'b1, s);
    ack = ~s;
  endtask : tx_byte

  // Byte in; the last byte gets NACK so the target lets go
  task automatic rx_byte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(last, s);
  endtask : rx_byte

  // Stop: data rises while the clock is high
  task automatic stop();
    #20;
    sda_low_o = 1'b1;
    #20;
    scl_o = 1'b1;
    #40;
    sda_low_o = 1'b0;
    #40;
  endtask : stop
endmodule : fcp_host_model

`default_nettype wire

// file: tb_top.sv
// Self-checking bench for the flow sensor command port
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  localparam int FIRST = 400;
  localparam int TICK = 1500;
  localparam int STOPW = 200;
  // Arbitrary identifier value
  localparam logic [31:0] PID = 32'h5a3c_0e71;
  logic clk, rst, sda_o, sda_oe, done, ok, alarm_n, scl, host_low, sda, ack;
  logic [1:0] sel;
  logic [6:0] addr;
  logic [15:0] flow, temp, arg;
  logic [7:0] rb [9];
  int fails = 0;
  int total_checks = 0;
  int cyc = 0;

  // Open-drain wire with pull-up
  assign sda = ~((sda_oe & ~sda_o) | host_low);

  fcp_cmd_port #(.FIRST_CYC(FIRST), .TICK_CYC(TICK), .STOP_CYC(STOPW),
    .PRODUCT_ID(PID)) fcp_cmd_port_i (
    .CLK_SYS_I(clk), .SYS_RST_I(rst), .SCL_I(scl), .SDA_I(sda),
    .SDA_O(sda_o), .SDA_OE_O(sda_oe), .ADDR_SEL_I(sel),
    .MEM_CHECK_DONE_I(done), .MEM_CHECK_OK_I(ok), .FLOW_I(flow),
    .TEMP_I(temp), .DATA_READY_ALARM_N_O(alarm_n));

  fcp_host_model fcp_host_model_i (.sda_i(sda), .scl_o(scl),
    .sda_low_o(host_low));

  // System clock, 8 ns period
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fails++;
      end_sim();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen,
      input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic end_sim();
    if (fails == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim

  // Expected checksum of one word, MSB first
  function automatic logic [7:0] crc_of(input logic [15:0] w);
    logic [7:0] c;
    c = 8'hff;
    for (int i = 15; i >= 0; i--) begin
      c = (c[7] ^ w[i]) ? ({c[6:0], 1'b0} ^ 8'h31) : {c[6:0], 1'b0};
    end
    return c;
  endfunction : crc_of

  // Compare one returned word and its checksum
  task automatic chk_word(input string nm, input logic [15:0] w,
      input int b);
    chk(nm, 32'(rb[b]), 32'(w[15:8]));
    chk(nm, 32'(rb[b + 1]), 32'(w[7:0]));
    chk(nm, 32'(rb[b + 2]), 32'(crc_of(w)));
  endtask : chk_word

  // Write frame: address, command, optional argument and checksum
  task automatic wr(input logic [6:0] a, input logic [15:0] c,
      input logic [15:0] w, input int nb, input logic [7:0] cx);
    logic k;
    @(negedge clk);
    fcp_host_model_i.start();
    fcp_host_model_i.tx_byte({a, 1'b0}, ack);
    fcp_host_model_i.tx_byte(c[15:8], k);
    fcp_host_model_i.tx_byte(c[7:0], k);
    if (nb == 5) begin
      fcp_host_model_i.tx_byte(w[15:8], k);
      fcp_host_model_i.tx_byte(w[7:0], k);
      fcp_host_model_i.tx_byte(crc_of(w) ^ cx, k);
    end
    fcp_host_model_i.stop();
  endtask : wr

  // Read frame of n bytes; the last one is refused by the host
  task automatic rd(input logic [6:0] a, input int n);
    @(negedge clk);
    fcp_host_model_i.start();
    fcp_host_model_i.tx_byte({a, 1'b1}, ack);
    for (int i = 0; i < n && ack === 1'b1; i++) begin
      fcp_host_model_i.rx_byte(i == n - 1, rb[i]);
    end
    fcp_host_model_i.stop();
  endtask : rd

  // Bounded wait for a fresh reading
  task automatic wait_low(input int lim);
    for (int n = 0; n < lim && alarm_n !== 1'b0; n++) begin
      @(negedge clk);
    end
  endtask : wait_low

  // Main sequence
  initial begin
    logic [15:0] st;
    rst = 1'b1;
    done = 1'b0;
    ok = 1'b0;
    flow = 16'h0;
    temp = 16'h0;
    arg = 16'h0;
    void'($urandom(63));
    sel = 2'($urandom_range(3));
    addr = 7'h2a + {5'h0, sel};
    repeat (8) @(negedge clk);
    rst = 1'b0;
    done = 1'b1;
    repeat (10) @(negedge clk);
    chk("alarm after reset", 32'(alarm_n), 32'h0);
    rd(addr, 1);
    chk("ack failed check", 32'(ack), 32'h0);
    @(negedge clk);
    rst = 1'b1;
    done = 1'b0;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    done = 1'b1;
    ok = 1'b1;
    repeat (10) @(negedge clk);
    rd(addr + 7'h04, 1);
    chk("ack wrong addr", 32'(ack), 32'h0);
    rd(addr, 1);
    chk("ack read idle", 32'(ack), 32'h0);
    wr(addr, 16'h3624, 16'h0, 2, 8'h0);
    chk("alarm reserved", 32'(alarm_n), 32'h0);
    wr(addr, 16'h3632, 16'h01f4, 5, 8'h5a);
    repeat (4) @(negedge clk);
    chk("alarm bad crc", 32'(alarm_n), 32'h0);
    wr(addr, fcp_pkg::CMD_PROD_ID, 16'h0, 2, 8'h0);
    rd(addr, 6);
    chk("ack id", 32'(ack), 32'h1);
    chk_word("id high", PID[31:16], 0);
    chk_word("id low", PID[15:0], 3);
    for (int i = 0; i < 9; i++) begin
      if (i == 4 || i == 5) begin
        continue;
      end
      @(negedge clk);
      arg = (i > 5) ? 16'($urandom_range(1000)) : 16'h0;
      flow = 16'($urandom);
      temp = 16'($urandom);
      wr(addr, fcp_pkg::START_CODES[i], arg, (i > 5) ? 5 : 2, 8'h0);
      chk("ack start", 32'(ack), 32'h1);
      repeat (4) @(negedge clk);
      chk("alarm start", 32'(alarm_n), 32'h1);
      rd(addr, 1);
      chk("ack early", 32'(ack), 32'h0);
      wait_low(FIRST);
      chk("alarm ready", 32'(alarm_n), 32'h0);
      rd(addr, 9);
      chk("ack meas", 32'(ack), 32'h1);
      chk_word("flow", flow, 0);
      chk_word("temp", temp, 3);
      st = {4'(i), 2'h0, (i > 5) ? arg[9:0] : 10'h3ff};
      chk_word("status", st, 6);
      chk("alarm read", 32'(alarm_n), 32'h1);
      rd(addr, 1);
      chk("ack stale", 32'(ack), 32'h0);
      wait_low(TICK);
      chk("alarm tick", 32'(alarm_n), 32'h0);
      rd(addr, 2);
      chk("flow lsb", 32'(rb[1]), 32'(flow[7:0]));
      chk("release", 32'(sda_oe), 32'h0);
      if (i < 8) begin
        wr(addr, fcp_pkg::CMD_STOP, 16'h0, 2, 8'h0);
        rd(addr, 1);
        chk("ack stopping", 32'(ack), 32'h0);
        repeat (STOPW) @(negedge clk);
      end else begin
        arg = 16'($urandom_range(1000));
        wr(addr, fcp_pkg::CMD_CONC, arg, 5, 8'h0);
        chk("ack conc upd", 32'(ack), 32'h1);
        wr(addr, fcp_pkg::CMD_PTR_RST, 16'h0, 2, 8'h0);
        wait_low(TICK);
        rd(addr, 9);
        chk_word("conc upd", {4'(i), 2'h0, arg[9:0]}, 6);
        wait_low(TICK);
        rd(addr, 2);
      end
    end
    wr(addr, fcp_pkg::CMD_CONC, 16'd1001, 5, 8'h0);
    chk("ack conc", 32'(ack), 32'h1);
    wait_low(TICK + 100);
    chk("alarm stopped", 32'(alarm_n), 32'h1);
    end_sim();
  end
endmodule : tb_top

`default_nettype wire
